/* hw/csi_pkg.sv */
/*
  Constants for the codec status, overspill and interrupt logic.
  Assumes one 100 MHz clock and a host port on an 8-bit parallel bus.
*/
// Summary of operation
// - Encode-ready sets on the last bit of an encoded byte and requests interrupt.
// - Encode-ready clears on an encode buffer read or when encode overspill sets.
// - Decode-ready sets when the decode shift register reloads from its buffer.
// - Decode-ready clears on a decode buffer write or while decode overspill is set.
// - Page-ready sets at page end, on the same edge that all eight power bits are written.
// - Page-ready clears on a power register read or when page overspill sets.
// - Encode overspill sets on a missed encode read; encode buffer then frozen.
// - Encode overspill clears on encode read, or decode write when both overspills set.
// - Decode overspill blocks buffer reloads; decode gets idle or encode loop data.
// - Decode overspill clears on decode write, or encode read when both are set.
// - Page overspill sets on an unread page; clears on power read or instruction B write.
// - Power register: bits 3..0 selected A/B level, bits 7..4 C level.
// - Interrupt on unread encode byte, decode buffer wanted, or fresh power result.
// - Unserviced lost condition clears its ready bit, sets overspill, stops its interrupt.
// - Buffers hold their data after overspill; power register updates every page.
// - Both data paths overspilled: any buffer access returns both to a clean start.
// - Interrupt request is an active-low open-drain output, wire-OR capable.
// - Registers selected by two address pins and read/write; status 00, power A0 high.
package csi_pkg;
  // Status register bit positions
  localparam int ST_ENC_RDY = 0;
  localparam int ST_DEC_RDY = 1;
  localparam int ST_PAGE_RDY = 2;
  localparam int ST_ENC_OVF = 3;
  localparam int ST_DEC_OVF = 4;
  localparam int ST_PAGE_OVF = 5;
  // Power register fields
  localparam int PWR_AB_LSB = 0;
  localparam int PWR_C_LSB = 4;
  // Host register select codes, {A1, A0}
  localparam logic [1:0] SEL_STATUS_OR_IRA = 2'h0;
  localparam logic [1:0] SEL_POWER_OR_IRB = 2'h1;
  localparam logic [1:0] SEL_CODEC_DATA = 2'h2;
  // Reset values and patterns
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] IDLE_PATTERN = 8'haa;
  localparam logic [7:0] POWER_RESET = 8'h00;
endpackage

/* hw/csi_acc_if.sv */
/*
  Host access events passed from the pin front end to the status core.
  Assumes both ends share the core clock.
*/
interface csi_acc_if;
  logic active;
  logic [1:0] sel;
  logic rd;
  logic done;
  logic [1:0] done_sel;
  logic done_rd;
  logic [7:0] wdata;
  modport port (output active, output sel, output rd, output done, output done_sel, output done_rd, output wdata);
  modport core (input active, input sel, input rd, input done, input done_sel, input done_rd, input wdata);
endinterface

/* hw/csi_host_port.sv */
/*
  Host pin front end: synchronises the asynchronous port pins and reports
  each completed access as a one-cycle pulse at chip select release.
  Assumes pins are stable for several clocks around each access.
*/
module csi_host_port
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Host pins
  input wire logic i_cs_n,
  input wire logic i_a0,
  input wire logic i_a1,
  input wire logic i_rw,
  input wire logic [7:0] i_d,
  // Access events
  csi_acc_if.port acc
);
  typedef struct packed {
    logic [11:0] s1;
    logic [11:0] s2;
    logic act_q;
    logic [1:0] sel_q;
    logic rd_q;
    logic [7:0] d_q;
    logic done;
  } csi_hp_t;

  csi_hp_t r;
  csi_hp_t next_r;
  logic act;

  // Second stage only; first stage feeds nothing else
  assign act = ~r.s2[11];

  always_comb
  begin
    next_r = r;
    next_r.s1 = {i_cs_n, i_a1, i_a0, i_rw, i_d};
    next_r.s2 = r.s1;
    next_r.act_q = act;
    next_r.done = 1'b0;
    if (act)
    begin
      next_r.sel_q = r.s2[10:9];
      next_r.rd_q = r.s2[8];
      next_r.d_q = r.s2[7:0];
    end
    // Side effects only at release, so a slow read sees stable flags
    if (r.act_q && !act)
    begin
      next_r.done = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      r <= '{s1: 12'hfff, s2: 12'hfff, act_q: 1'b0, sel_q: 2'h0, rd_q: 1'b0, d_q: 8'h00, done: 1'b0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign acc.active = act;
  assign acc.sel = r.s2[10:9];
  assign acc.rd = r.s2[8];
  assign acc.done = r.done;
  assign acc.done_sel = r.sel_q;
  assign acc.done_rd = r.rd_q;
  assign acc.wdata = r.d_q;
endmodule

/* hw/csi_status_irq.sv */
/*
  Status, overspill and interrupt core of the codec host port, with the
  encode and decode byte buffers and the page power register.
  Assumes the codec data path gives same-clock pulses for byte and page
  boundaries; host pins arrive asynchronously.
*/
module csi_status_irq
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Host port pins
  input wire logic I_CS_N,
  input wire logic I_A0,
  input wire logic I_A1,
  input wire logic I_RW,
  input wire logic [7:0] I_D,
  output logic [7:0] O_D,
  output logic O_D_OE,
  // Interrupt request pin, open drain
  output logic O_IRQ_N,
  output logic O_IRQ_N_OE,
  // Encode path
  input wire logic I_ENC_LAST_BIT,
  input wire logic [7:0] I_ENC_SHIFT,
  // Decode path
  input wire logic I_DEC_RELOAD,
  input wire logic I_LOOP_SEL,
  output logic [7:0] O_DEC_BYTE,
  output logic O_DEC_LOAD,
  // Page power results
  input wire logic I_PAGE_DONE,
  input wire logic [3:0] I_PWR_AB,
  input wire logic [3:0] I_PWR_C
);
  typedef struct packed {
    logic [7:0] enc_buf;
    logic enc_rdy;
    logic enc_ovf;
    logic [7:0] dec_buf;
    logic dec_full;
    logic dec_rdy;
    logic dec_ovf;
    logic [7:0] pwr;
    logic page_rdy;
    logic page_ovf;
    logic [7:0] dec_byte;
    logic dec_load;
    logic [7:0] dout;
    logic dout_oe;
    logic irq;
  } csi_core_t;

  csi_core_t r;
  csi_core_t next_r;
  csi_acc_if acc ();

  logic rd_status;
  logic rd_power;
  logic rd_enc;
  logic wr_dec;
  logic wr_irb;
  logic both_ovf;
  logic enc_clr;
  logic dec_clr;
  logic [7:0] status;

  csi_host_port u_port
  (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_cs_n(I_CS_N),
    .i_a0(I_A0),
    .i_a1(I_A1),
    .i_rw(I_RW),
    .i_d(I_D),
    .acc(acc)
  );

  // Completed host accesses, decoded by address and direction
  assign rd_status = acc.done && acc.done_rd && acc.done_sel == csi_pkg::SEL_STATUS_OR_IRA;
  assign rd_power = acc.done && acc.done_rd && acc.done_sel == csi_pkg::SEL_POWER_OR_IRB;
  assign rd_enc = acc.done && acc.done_rd && acc.done_sel == csi_pkg::SEL_CODEC_DATA;
  assign wr_dec = acc.done && !acc.done_rd && acc.done_sel == csi_pkg::SEL_CODEC_DATA;
  assign wr_irb = acc.done && !acc.done_rd && acc.done_sel == csi_pkg::SEL_POWER_OR_IRB;
  assign both_ovf = r.enc_ovf && r.dec_ovf;
  // Clears as seen by same-cycle events, so the hardware set wins
  assign enc_clr = rd_enc || (both_ovf && wr_dec);
  assign dec_clr = wr_dec || (both_ovf && rd_enc);

  always_comb
  begin
    status = 8'h00;
    status[csi_pkg::ST_ENC_RDY] = r.enc_rdy;
    status[csi_pkg::ST_DEC_RDY] = r.dec_rdy;
    status[csi_pkg::ST_PAGE_RDY] = r.page_rdy;
    status[csi_pkg::ST_ENC_OVF] = r.enc_ovf;
    status[csi_pkg::ST_DEC_OVF] = r.dec_ovf;
    status[csi_pkg::ST_PAGE_OVF] = r.page_ovf;
  end

  always_comb
  begin
    next_r = r;
    next_r.dec_load = 1'b0;

    // Host clears first, so a same-cycle hardware set wins below
    if (both_ovf && (rd_enc || wr_dec))
    begin
      next_r.enc_ovf = 1'b0;
      next_r.dec_ovf = 1'b0;
      next_r.enc_rdy = 1'b0;
      next_r.dec_rdy = 1'b0;
      next_r.dec_full = 1'b0;
    end
    else
    begin
      if (rd_enc)
      begin
        next_r.enc_rdy = 1'b0;
        next_r.enc_ovf = 1'b0;
      end
      if (wr_dec)
      begin
        next_r.dec_rdy = 1'b0;
        next_r.dec_ovf = 1'b0;
      end
    end
    if (wr_dec)
    begin
      next_r.dec_buf = acc.wdata;
      next_r.dec_full = 1'b1;
    end
    if (rd_power)
    begin
      next_r.page_rdy = 1'b0;
      next_r.page_ovf = 1'b0;
    end
    if (wr_irb)
    begin
      next_r.page_ovf = 1'b0;
    end

    // Encode byte boundary
    if (I_ENC_LAST_BIT && (!r.enc_ovf || enc_clr))
    begin
      if (r.enc_rdy && !enc_clr)
      begin
        // Missed byte: buffer keeps the unread data
        next_r.enc_ovf = 1'b1;
        next_r.enc_rdy = 1'b0;
      end
      else
      begin
        next_r.enc_buf = I_ENC_SHIFT;
        next_r.enc_rdy = 1'b1;
      end
    end

    // Decode byte boundary
    if (I_DEC_RELOAD)
    begin
      next_r.dec_load = 1'b1;
      next_r.dec_byte = I_LOOP_SEL ? I_ENC_SHIFT : csi_pkg::IDLE_PATTERN;
      if (r.dec_ovf && !dec_clr)
      begin
        next_r.dec_rdy = 1'b0;
      end
      else if (r.dec_rdy && !dec_clr)
      begin
        next_r.dec_ovf = 1'b1;
        next_r.dec_rdy = 1'b0;
      end
      else
      begin
        // First reload after reset finds no data and plays idle, or encode loop data when loop is selected
        if (r.dec_full || wr_dec)
        begin
          next_r.dec_byte = wr_dec ? acc.wdata : r.dec_buf;
        end
        next_r.dec_full = 1'b0;
        next_r.dec_rdy = 1'b1;
      end
    end

    // Page boundary: power always updated, ready flag lands on the same edge as the value
    if (I_PAGE_DONE)
    begin
      next_r.pwr = {I_PWR_C, I_PWR_AB};
      if (r.page_rdy && !rd_power)
      begin
        next_r.page_ovf = 1'b1;
        next_r.page_rdy = 1'b0;
      end
      else if (!r.page_ovf || wr_irb || rd_power)
      begin
        next_r.page_rdy = 1'b1;
      end
    end

    // Read data from flops; bus driven only during a read of a mapped register
    next_r.dout_oe = acc.active && acc.rd && acc.sel != 2'h3;
    case (acc.sel)
      csi_pkg::SEL_STATUS_OR_IRA: next_r.dout = status;
      csi_pkg::SEL_POWER_OR_IRB: next_r.dout = r.pwr;
      csi_pkg::SEL_CODEC_DATA: next_r.dout = r.enc_buf;
      default: next_r.dout = 8'h00;
    endcase

    // Ready bits are cleared on overspill, so they alone gate the request
    next_r.irq = next_r.enc_rdy || next_r.dec_rdy || next_r.page_rdy;
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      r <= '{enc_buf: csi_pkg::BYTE_RESET, enc_rdy: 1'b0, enc_ovf: 1'b0,
             dec_buf: csi_pkg::BYTE_RESET, dec_full: 1'b0, dec_rdy: 1'b0, dec_ovf: 1'b0,
             pwr: csi_pkg::POWER_RESET, page_rdy: 1'b0, page_ovf: 1'b0,
             dec_byte: csi_pkg::IDLE_PATTERN, dec_load: 1'b0,
             dout: csi_pkg::BYTE_RESET, dout_oe: 1'b0, irq: 1'b0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign O_D = r.dout;
  assign O_D_OE = r.dout_oe;
  // Pulls low only; the external pull-up makes the high level
  assign O_IRQ_N = 1'b0;
  assign O_IRQ_N_OE = r.irq;
  assign O_DEC_BYTE = r.dec_byte;
  assign O_DEC_LOAD = r.dec_load;
endmodule

/* tb/csi_status_irq_monitor.sv */
/*
  Port assertions for csi_status_irq.
  Assumes it is bound to that module.
*/
module csi_status_irq_monitor
(
  // Clock, reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Host pins
  input wire logic I_CS_N,
  input wire logic I_A1,
  input wire logic I_RW,
  input wire logic O_D_OE,
  // Interrupt and paths
  input wire logic O_IRQ_N,
  input wire logic O_IRQ_N_OE,
  input wire logic I_ENC_LAST_BIT,
  input wire logic I_DEC_RELOAD,
  input wire logic O_DEC_LOAD,
  input wire logic I_PAGE_DONE
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);
  wire logic ev = I_ENC_LAST_BIT | I_DEC_RELOAD | I_PAGE_DONE;
  // Eight idle cycles: any access side effect has landed
  sequence host_idle;
    I_CS_N [*8];
  endsequence
  sequence calm;
    !ev && !$past(ev);
  endsequence
  chk_irq_pin_low: assert property (!O_IRQ_N) else $error("irq level");
  chk_irq_hold: assert property (host_idle ##0 calm ##0 O_IRQ_N_OE |=> O_IRQ_N_OE) else $error("irq drop");
  chk_irq_stay_off: assert property (host_idle ##0 calm ##0 !O_IRQ_N_OE |=> !O_IRQ_N_OE) else $error("irq");
  chk_irq_cause: assert property ($rose(O_IRQ_N_OE) |-> $past(ev) || $past(ev, 2)) else $error("irq");
  chk_reload_load: assert property (I_DEC_RELOAD |=> O_DEC_LOAD) else $error("no load");
  chk_load_cause: assert property (O_DEC_LOAD |-> $past(I_DEC_RELOAD)) else $error("stray load");
  chk_idle_float: assert property (host_idle |-> !O_D_OE) else $error("idle drive");
  chk_read_drive: assert property ((!I_CS_N && I_RW && !I_A1) [*5] |-> O_D_OE) else $error("no drive");
endmodule
bind csi_status_irq csi_status_irq_monitor mon (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CS_N(I_CS_N), .I_A1(I_A1),
  .I_RW(I_RW), .O_D_OE(O_D_OE), .O_IRQ_N(O_IRQ_N), .O_IRQ_N_OE(O_IRQ_N_OE), .I_ENC_LAST_BIT(I_ENC_LAST_BIT),
  .I_DEC_RELOAD(I_DEC_RELOAD), .O_DEC_LOAD(O_DEC_LOAD), .I_PAGE_DONE(I_PAGE_DONE));

/* tb/csi_host_model.sv */
/*
  Host processor on the 8-bit port.
  Assumes the pins of csi_status_irq.
*/
module csi_host_model
(
  // Clock
  input wire logic clk,
  // Device pins
  output logic cs_n = 1'h1,
  output logic [1:0] sel = 2'h0,
  output logic rw = 1'h1,
  output logic [7:0] d = 8'h00,
  input wire logic [7:0] q,
  input wire logic q_oe,
  // Read results
  output logic stb = 1'h0,
  output logic [7:0] val = 8'h00
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pins held well past the two-flop sync
  task automatic acc(input logic [1:0] s, input logic r, input logic [7:0] w);
    @(posedge clk) #1;
    sel = s;
    rw = r;
    d = r ? ~d : w;
    cs_n = 1'h0;
    repeat (6) @(posedge clk);
    #1;
    val = q_oe ? q : ~q;
    stb = r;
    cs_n = 1'h1;
    @(posedge clk) #1;
    stb = 1'h0;
    repeat (6) @(posedge clk);
    #1;
  endtask
endmodule

/* tb/test_codec_status_interrupt_logic.sv */
/*
  Bench for csi_status_irq.
  Assumes the host model and the bound monitor.
*/
module test_codec_status_interrupt_logic;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'h0, rst = 1'h1, enc = 1'h0, rel = 1'h0, pg = 1'h0, lp = 1'h0;
  logic cs_n, rw, oe, ld, stb, irq_oe, irq_drv;
  logic [1:0] sel;
  logic [7:0] b = 8'h00, x, y, d, q, dec, val;
  int n_fail = 0, comparisons = 0;
  int n_rel = 0, n_load = 0;
  logic [7:0] exp_q[$];
  wire logic irq_n = irq_oe ? irq_drv : 1'h1;
  always #5 clk = ~clk;
  csi_status_irq uut (.I_CLK(clk), .I_SYS_RST(rst), .I_CS_N(cs_n), .I_A0(sel[0]), .I_A1(sel[1]), .I_RW(rw), .I_D(d),
    .O_D(q), .O_D_OE(oe), .O_IRQ_N(irq_drv), .O_IRQ_N_OE(irq_oe), .I_ENC_LAST_BIT(enc), .I_ENC_SHIFT(b),
    .I_DEC_RELOAD(rel), .I_LOOP_SEL(lp), .O_DEC_BYTE(dec), .O_DEC_LOAD(ld), .I_PAGE_DONE(pg), .I_PWR_AB(b[3:0]),
    .I_PWR_C(b[7:4]));
  csi_host_model host (.clk(clk), .cs_n(cs_n), .sel(sel), .rw(rw), .d(d), .q(q), .q_oe(oe), .stb(stb), .val(val));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_irq(input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED irq expected %h seen %h", e, g);
    end
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    exp_q.push_back(e);
    host.acc(s, 1'h1, 8'h00);
  endtask
  // Event pulse; b carries byte, levels and loop data
  task automatic pu(input int k, input logic [7:0] v);
    @(posedge clk) #1;
    if (k == 1)
      n_rel++;
    b = v;
    {enc, rel, pg} = {k == 0, k == 1, k == 2};
    @(posedge clk) #1;
    {enc, rel, pg} = 3'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  always @(posedge clk)
    if (stb === 1'h1)
      chk("read", exp_q.size() > 0 ? exp_q.pop_front() : ~val, val);
  always @(posedge clk)
    if (ld === 1'h1)
      n_load++;
  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  initial
  begin
    void'($urandom(32'hdd675a3b));
    // Distinct from each other, from zero and from the idle byte
    x = {2'h1, 6'($urandom)};
    y = {2'h3, 6'($urandom)};
    repeat (3) @(posedge clk);
    #1 rst = 1'h0;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h3, 8'hff);
    pu(0, x);
    chk_irq(1'h0, irq_n);
    rd(2'h0, 8'h01);
    rd(2'h2, x);
    rd(2'h0, 8'h00);
    chk_irq(1'h1, irq_n);
    pu(0, x);
    pu(0, y);
    rd(2'h0, 8'h08);
    chk_irq(1'h1, irq_n);
    rd(2'h2, x);
    rd(2'h0, 8'h00);
    pu(1, x);
    chk("dec", 8'haa, dec);
    rd(2'h0, 8'h02);
    host.acc(2'h2, 1'h0, y);
    rd(2'h0, 8'h00);
    pu(1, x);
    chk("dec", y, dec);
    pu(1, x);
    rd(2'h0, 8'h10);
    lp = 1'h1;
    pu(1, x);
    chk("dec", x, dec);
    lp = 1'h0;
    pu(1, x);
    chk("dec", 8'haa, dec);
    host.acc(2'h2, 1'h0, y);
    rd(2'h0, 8'h00);
    pu(2, x);
    chk_irq(1'h0, irq_n);
    rd(2'h0, 8'h04);
    rd(2'h1, x);
    rd(2'h0, 8'h00);
    pu(2, x);
    pu(2, y);
    rd(2'h0, 8'h20);
    rd(2'h1, y);
    pu(2, x);
    pu(2, y);
    host.acc(2'h1, 1'h0, x);
    rd(2'h0, 8'h00);
    repeat (2) pu(1, x);
    pu(0, x);
    pu(0, y);
    rd(2'h0, 8'h18);
    host.acc(2'h2, 1'h0, y);
    rd(2'h0, 8'h00);
    repeat (2) pu(1, x);
    pu(0, y);
    pu(0, x);
    rd(2'h2, y);
    rd(2'h0, 8'h00);
    chk("loads", 8'(n_rel), 8'(n_load));
    complete_run();
  end
endmodule
